// [hdl/eppp_pkg.sv]
package eppp_pkg;

    localparam logic [2:0] OFS_DATA    = 3'h0;
    localparam logic [2:0] OFS_STATUS  = 3'h1;
    localparam logic [2:0] OFS_CONTROL = 3'h2;
    localparam logic [2:0] OFS_ADDR    = 3'h3;

    localparam int CTL_STROBE = 0;
    localparam int CTL_AUTO_LINE_FEED = 1;
    localparam int CTL_INIT   = 2;
    localparam int CTL_SELECT = 3;
    localparam int CTL_INTERRUPT_REQUEST_ENABLE   = 4;
    localparam int CTL_DIR    = 5;
    localparam int CTL_WIDTH  = 6;

    localparam logic [CTL_WIDTH-1:0] CTL_RESET  = 6'h00;
    localparam logic [7:0]           BYTE_ZERO  = 8'h00;

    localparam int CLK_HZ        = 25000000;
    localparam int WDOG_NS       = 10000;
    localparam int WDOG_CYCLES   = (WDOG_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int WDOG_W        = 10;

    localparam logic [1:0] MODE_SPP  = 2'h0;
    localparam logic [1:0] MODE_BIDI = 2'h1;
    localparam logic [1:0] MODE_EPP  = 2'h2;
    localparam logic [1:0] MODE_ECP  = 2'h3;

    typedef enum logic [2:0] {
        EPPP_IDLE   = 3'b000,
        EPPP_PRE    = 3'b001,
        EPPP_STROBE = 3'b010,
        EPPP_FINISH = 3'b011,
        EPPP_ABORT  = 3'b100
    } eppp_state_e;

endpackage : eppp_pkg

// [hdl/eppp_wdog_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface eppp_wdog_if;
    logic run;
    logic expired;

    modport ctrl (output run, input expired);
    modport timer (input run, output expired);
endinterface : eppp_wdog_if

`default_nettype wire

// [hdl/eppp_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none

// Counts clock cycles while run is high; expired rises once the limit is reached.
module eppp_watchdog
    import eppp_pkg::*;
#(
    parameter int LIMIT = WDOG_CYCLES
) (
    // Clock and reset
    input wire logic  CLK,
    input wire logic  RESETN,
    // Control
    eppp_wdog_if.timer wd
);

    logic [WDOG_W-1:0] count;
    logic [WDOG_W-1:0] next_count;
    logic              expired;
    logic              next_expired;

    always_comb begin
        next_count   = count;
        next_expired = 1'b0;
        if (!wd.run) begin
            next_count = '0;
        end else if (count >= WDOG_W'(LIMIT - 1)) begin
            next_expired = 1'b1;
        end else begin
            next_count = count + WDOG_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            count   <= '0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            expired <= next_expired;
        end
    end

    assign wd.expired = expired;

endmodule : eppp_watchdog

`default_nettype wire

// [hdl/eppp_port.sv]
`timescale 1ns/1ps
`default_nettype none

module eppp_port
    import eppp_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESETN,
    // Host I/O cycle
    input  wire logic [2:0] IO_ADDR,
    input  wire logic       IO_WR,
    input  wire logic       IO_RD,
    input  wire logic [7:0] IO_WDATA,
    output var  logic [7:0] IO_RDATA,
    output var  logic       IO_READY,
    input  wire logic [1:0] PORT_MODE,
    // Printer status inputs
    input  wire logic       FAULT_INPUT_LOW,
    input  wire logic       PRINTER_ONLINE,
    input  wire logic       PAPER_OUT,
    input  wire logic       CHAR_ACCEPTED_LOW,
    input  wire logic       BUSY,
    // Control outputs
    output var  logic       DATA_STROBE_PIN_LOW,
    output var  logic       LINE_FEED_PIN_LOW,
    output var  logic       PRINTER_INIT_LOW,
    output var  logic       SELECT_PRINTER_PIN_LOW,
    output var  logic       IRQ,
    // EPP handshake
    output var  logic       WRITE_DIRECTION_LOW,
    output var  logic       DATA_PHASE_STROBE_LOW,
    output var  logic       ADDRESS_PHASE_STROBE_LOW,
    input  wire logic       WAIT_HANDSHAKE_LOW,
    // Data lines
    input  wire logic [7:0] PORT_DATA_IN,
    output var  logic [7:0] PORT_DATA_OUT,
    output var  logic       PORT_DATA_OE_LOW
);

    eppp_wdog_if wd ();

    eppp_state_e            state;
    eppp_state_e            next_state;
    logic [CTL_WIDTH-1:0]   ctl;
    logic [CTL_WIDTH-1:0]   next_ctl;
    logic [7:0]             spp_data;
    logic [7:0]             next_spp_data;
    logic [7:0]             epp_address;
    logic [7:0]             next_epp_address;
    logic [7:0]             epp_data;
    logic [7:0]             next_epp_data;
    logic                   epp_timeout_flag;
    logic                   next_epp_timeout_flag;
    logic                   cyc_write;
    logic                   next_cyc_write;
    logic                   cyc_addr;
    logic                   next_cyc_addr;
    logic                   ack_prev;
    logic                   next_irq;
    logic [7:0]             rdata;
    logic [7:0]             next_rdata;
    logic                   ready;
    logic                   next_ready;
    logic                   rd_busy;
    logic                   next_rd_busy;
    logic                   drive_write;
    logic                   data_oe_low;
    logic [7:0]             data_out;
    logic                   wr_low;
    logic                   dstb_low;
    logic                   astb_low;
    logic                   epp_mode;
    logic                   ack_rise;
    logic [7:0]             status_now;

    function automatic logic is_epp_port(input logic [2:0] a);
        return a >= OFS_ADDR;
    endfunction

    assign epp_mode = (PORT_MODE == MODE_EPP);
    assign ack_rise = CHAR_ACCEPTED_LOW && !ack_prev;
    assign wd.run   = (state == EPPP_PRE) || (state == EPPP_STROBE);

    // Status image: bits 1 and 2 fixed low, bit 7 complements busy.
    assign status_now = {!BUSY, CHAR_ACCEPTED_LOW, PAPER_OUT, PRINTER_ONLINE,
                         FAULT_INPUT_LOW, 2'b00, epp_timeout_flag};

    eppp_watchdog #(
        .LIMIT (WDOG_LIMIT)
    ) u_wdog (
        .CLK    (CLK),
        .RESETN (RESETN),
        .wd     (wd.timer)
    );

    // Host register access and EPP cycle sequencing.
    always_comb begin
        next_state            = state;
        next_ctl              = ctl;
        next_spp_data         = spp_data;
        next_epp_address      = epp_address;
        next_epp_data         = epp_data;
        next_epp_timeout_flag = epp_timeout_flag;
        next_cyc_write        = cyc_write;
        next_cyc_addr         = cyc_addr;
        next_rdata            = rdata;
        next_ready            = 1'b0;
        next_rd_busy          = rd_busy;
        next_irq              = 1'b0;
        if (!(IO_RD || IO_WR)) begin
            next_rd_busy = 1'b0;
        end
        if (ctl[CTL_INTERRUPT_REQUEST_ENABLE] && ack_rise) begin
            next_irq = 1'b1;
        end
        case (state)
            EPPP_IDLE: begin
                if (IO_WR && !ready && !rd_busy) begin
                    next_rd_busy = 1'b1;
                    case (IO_ADDR)
                        OFS_DATA: begin
                            next_spp_data = IO_WDATA;
                            next_ready    = 1'b1;
                        end
                        OFS_STATUS: begin
                            if (IO_WDATA[0]) begin
                                next_epp_timeout_flag = 1'b0;
                            end
                            next_ready = 1'b1;
                        end
                        OFS_CONTROL: begin
                            next_ctl   = IO_WDATA[CTL_WIDTH-1:0];
                            next_ready = 1'b1;
                        end
                        default: begin
                            if (epp_mode) begin
                                next_cyc_write = !ctl[CTL_DIR];
                                next_cyc_addr  = (IO_ADDR == OFS_ADDR);
                                if (IO_ADDR == OFS_ADDR) begin
                                    next_epp_address = IO_WDATA;
                                end else begin
                                    next_epp_data = IO_WDATA;
                                end
                                next_state = EPPP_PRE;
                            end else begin
                                next_ready = 1'b1;
                            end
                        end
                    endcase
                end else if (IO_RD && !ready && !rd_busy) begin
                    next_rd_busy = 1'b1;
                    case (IO_ADDR)
                        OFS_DATA:    next_rdata = PORT_DATA_IN;
                        OFS_STATUS:  next_rdata = status_now;
                        OFS_CONTROL: next_rdata = {2'b00, ctl};
                        default:     next_rdata = BYTE_ZERO;
                    endcase
                    if (is_epp_port(IO_ADDR) && epp_mode) begin
                        next_cyc_write = 1'b0;
                        next_cyc_addr  = (IO_ADDR == OFS_ADDR);
                        next_state     = EPPP_PRE;
                    end else begin
                        next_ready = 1'b1;
                    end
                end
            end
            EPPP_PRE: begin
                if (!WAIT_HANDSHAKE_LOW) begin
                    next_state = EPPP_STROBE;
                end
            end
            EPPP_STROBE: begin
                if (wd.expired) begin
                    next_state = EPPP_ABORT;
                end else if (WAIT_HANDSHAKE_LOW) begin
                    if (!cyc_write) begin
                        next_rdata = PORT_DATA_IN;
                        if (cyc_addr) begin
                            next_epp_address = PORT_DATA_IN;
                        end else begin
                            next_epp_data = PORT_DATA_IN;
                        end
                    end
                    next_state = EPPP_FINISH;
                end
            end
            EPPP_ABORT: begin
                next_epp_timeout_flag = 1'b1;
                next_ready            = 1'b1;
                next_state            = EPPP_IDLE;
            end
            EPPP_FINISH: begin
                next_ready = 1'b1;
                next_state = EPPP_IDLE;
            end
            default: next_state = EPPP_IDLE;
        endcase
        if (state == EPPP_PRE && wd.expired) begin
            next_state = EPPP_ABORT;
        end
    end

    // Pin drive; outside a cycle the data register, port mode and direction bit rule.
    always_comb begin
        drive_write = (state == EPPP_PRE || state == EPPP_STROBE) && cyc_write;
        if (drive_write || ((state == EPPP_PRE || state == EPPP_STROBE)
                            && ctl[CTL_STROBE])) begin
            wr_low      = 1'b0;
            data_oe_low = 1'b0;
        end else if (state == EPPP_PRE || state == EPPP_STROBE) begin
            wr_low      = 1'b1;
            data_oe_low = 1'b1;
        end else begin
            wr_low      = 1'b1;
            data_oe_low = (PORT_MODE == MODE_SPP) ? 1'b0 : ctl[CTL_DIR];
        end
        if (state == EPPP_PRE || state == EPPP_STROBE) begin
            data_out = cyc_addr ? epp_address : epp_data;
        end else begin
            data_out = spp_data;
        end
        dstb_low = !(state == EPPP_STROBE && !cyc_addr);
        astb_low = !(state == EPPP_STROBE && cyc_addr);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state                    <= EPPP_IDLE;
            ctl                      <= CTL_RESET;
            spp_data                 <= BYTE_ZERO;
            epp_address              <= BYTE_ZERO;
            epp_data                 <= BYTE_ZERO;
            epp_timeout_flag         <= 1'b0;
            cyc_write                <= 1'b0;
            cyc_addr                 <= 1'b0;
            // The acknowledge line idles high, so no false edge follows reset.
            ack_prev                 <= 1'b1;
            rdata                    <= BYTE_ZERO;
            ready                    <= 1'b0;
            rd_busy                  <= 1'b0;
            IO_RDATA                 <= BYTE_ZERO;
            IO_READY                 <= 1'b0;
            IRQ                      <= 1'b0;
            DATA_STROBE_PIN_LOW      <= 1'b1;
            LINE_FEED_PIN_LOW        <= 1'b1;
            PRINTER_INIT_LOW         <= 1'b0;
            SELECT_PRINTER_PIN_LOW   <= 1'b1;
            WRITE_DIRECTION_LOW      <= 1'b1;
            DATA_PHASE_STROBE_LOW    <= 1'b1;
            ADDRESS_PHASE_STROBE_LOW <= 1'b1;
            PORT_DATA_OUT            <= BYTE_ZERO;
            PORT_DATA_OE_LOW         <= 1'b0;
        end else begin
            state                    <= next_state;
            ctl                      <= next_ctl;
            spp_data                 <= next_spp_data;
            epp_address              <= next_epp_address;
            epp_data                 <= next_epp_data;
            epp_timeout_flag         <= next_epp_timeout_flag;
            cyc_write                <= next_cyc_write;
            cyc_addr                 <= next_cyc_addr;
            ack_prev                 <= CHAR_ACCEPTED_LOW;
            rdata                    <= next_rdata;
            ready                    <= next_ready;
            rd_busy                  <= next_rd_busy;
            IO_RDATA                 <= next_rdata;
            IO_READY                 <= next_ready;
            IRQ                      <= next_irq;
            DATA_STROBE_PIN_LOW      <= !next_ctl[CTL_STROBE];
            LINE_FEED_PIN_LOW        <= !next_ctl[CTL_AUTO_LINE_FEED];
            PRINTER_INIT_LOW         <= next_ctl[CTL_INIT];
            SELECT_PRINTER_PIN_LOW   <= !next_ctl[CTL_SELECT];
            WRITE_DIRECTION_LOW      <= wr_low;
            DATA_PHASE_STROBE_LOW    <= dstb_low;
            ADDRESS_PHASE_STROBE_LOW <= astb_low;
            PORT_DATA_OUT            <= data_out;
            PORT_DATA_OE_LOW         <= data_oe_low;
        end
    end

endmodule : eppp_port

`default_nettype wire

// [tb/eppp_port_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module eppp_port_chk
    import eppp_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    // Clock, reset and host side
    input wire logic       CLK,
    input wire logic       RESETN,
    input wire logic [2:0] IO_ADDR,
    input wire logic       IO_WR,
    input wire logic       IO_RD,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic       IO_READY,
    input wire logic [1:0] PORT_MODE,
    // Printer side
    input wire logic       FAULT_INPUT_LOW,
    input wire logic       PRINTER_ONLINE,
    input wire logic       PAPER_OUT,
    input wire logic       CHAR_ACCEPTED_LOW,
    input wire logic       BUSY,
    input wire logic       DATA_STROBE_PIN_LOW,
    input wire logic       LINE_FEED_PIN_LOW,
    input wire logic       PRINTER_INIT_LOW,
    input wire logic       SELECT_PRINTER_PIN_LOW,
    input wire logic       IRQ,
    // Handshake and data lines
    input wire logic       WRITE_DIRECTION_LOW,
    input wire logic       DATA_PHASE_STROBE_LOW,
    input wire logic       ADDRESS_PHASE_STROBE_LOW,
    input wire logic       WAIT_HANDSHAKE_LOW,
    input wire logic [7:0] PORT_DATA_OUT,
    input wire logic       PORT_DATA_OE_LOW
);
    localparam int STB_MAX = WDOG_LIMIT + 4;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_status_low;
        IO_READY && IO_RD && IO_ADDR == OFS_STATUS |-> IO_RDATA[2:1] == 2'h0;
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status spare bits set");

    property p_status_lines;
        IO_READY && IO_RD && IO_ADDR == OFS_STATUS |-> IO_RDATA[7:3] == {~$past(BUSY),
            $past(CHAR_ACCEPTED_LOW), $past(PAPER_OUT), $past(PRINTER_ONLINE),
            $past(FAULT_INPUT_LOW)};
    endproperty
    a_status_lines: assert property (p_status_lines)
        else $error("status line bits wrong");

    property p_ctl_read;
        IO_READY && IO_RD && IO_ADDR == OFS_CONTROL |-> IO_RDATA[7:6] == 2'h0;
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control top bits set");

    property p_ctl_pins;
        IO_READY && IO_WR && IO_ADDR == OFS_CONTROL |-> ##2
            {SELECT_PRINTER_PIN_LOW, PRINTER_INIT_LOW, LINE_FEED_PIN_LOW, DATA_STROBE_PIN_LOW}
            == (4'hB ^ $past(IO_WDATA[3:0], 2));
    endproperty
    a_ctl_pins: assert property (p_ctl_pins)
        else $error("control pins wrong");

    property p_irq_src;
        IRQ |-> $past(CHAR_ACCEPTED_LOW) && !$past(CHAR_ACCEPTED_LOW, 2);
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("irq without ack edge");

    property p_irq_pulse;
        IRQ |=> !IRQ;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq longer than a pulse");

    property p_wait_first;
        $fell(DATA_PHASE_STROBE_LOW) || $fell(ADDRESS_PHASE_STROBE_LOW)
            |-> !$past(WAIT_HANDSHAKE_LOW, 2);
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("strobe before wait ready");

    property p_strobe_bound;
        $fell(DATA_PHASE_STROBE_LOW) |-> ##[1:STB_MAX] DATA_PHASE_STROBE_LOW;
    endproperty
    a_strobe_bound: assert property (p_strobe_bound)
        else $error("strobe not ended by watchdog");

    property p_epp_only;
        PORT_MODE != MODE_EPP && $past(PORT_MODE) != MODE_EPP
            |-> DATA_PHASE_STROBE_LOW && ADDRESS_PHASE_STROBE_LOW;
    endproperty
    a_epp_only: assert property (p_epp_only)
        else $error("strobe outside epp mode");

    property p_spp_out;
        (PORT_MODE == MODE_SPP) [*3] |-> !PORT_DATA_OE_LOW;
    endproperty
    a_spp_out: assert property (p_spp_out)
        else $error("printer mode not driving");

    property p_write_drive;
        !WRITE_DIRECTION_LOW && !(DATA_PHASE_STROBE_LOW && ADDRESS_PHASE_STROBE_LOW)
            |-> !PORT_DATA_OE_LOW;
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("write cycle not driving");

    property p_write_hold;
        !WRITE_DIRECTION_LOW && !(DATA_PHASE_STROBE_LOW && ADDRESS_PHASE_STROBE_LOW)
            && !($past(DATA_PHASE_STROBE_LOW) && $past(ADDRESS_PHASE_STROBE_LOW))
            |-> $stable(PORT_DATA_OUT);
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write byte moved");
endmodule // eppp_port_chk

bind eppp_port eppp_port_chk #(.WDOG_LIMIT(WDOG_LIMIT)) u_chk (
    .CLK(CLK), .RESETN(RESETN), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_READY(IO_READY), .PORT_MODE(PORT_MODE),
    .FAULT_INPUT_LOW(FAULT_INPUT_LOW), .PRINTER_ONLINE(PRINTER_ONLINE),
    .PAPER_OUT(PAPER_OUT), .CHAR_ACCEPTED_LOW(CHAR_ACCEPTED_LOW), .BUSY(BUSY),
    .DATA_STROBE_PIN_LOW(DATA_STROBE_PIN_LOW), .LINE_FEED_PIN_LOW(LINE_FEED_PIN_LOW),
    .PRINTER_INIT_LOW(PRINTER_INIT_LOW), .SELECT_PRINTER_PIN_LOW(SELECT_PRINTER_PIN_LOW),
    .IRQ(IRQ), .WRITE_DIRECTION_LOW(WRITE_DIRECTION_LOW),
    .DATA_PHASE_STROBE_LOW(DATA_PHASE_STROBE_LOW),
    .ADDRESS_PHASE_STROBE_LOW(ADDRESS_PHASE_STROBE_LOW),
    .WAIT_HANDSHAKE_LOW(WAIT_HANDSHAKE_LOW), .PORT_DATA_OUT(PORT_DATA_OUT),
    .PORT_DATA_OE_LOW(PORT_DATA_OE_LOW)
);

`default_nettype wire

// [tb/eppp_periph.sv]
`timescale 1ns/1ps
`default_nettype none

module eppp_periph (
    // Clock and test controls
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic [1:0] lat,
    input  wire logic [7:0] rd_byte,
    // Cable from the port
    input  wire logic       dstb_low,
    input  wire logic       astb_low,
    input  wire logic       wr_low,
    input  wire logic       oe_low,
    input  wire logic [7:0] dout,
    output var  logic       wait_low,
    output var  logic [7:0] din,
    // What the peripheral saw
    output var  logic [7:0] got,
    output var  logic       got_adr,
    output var  logic       got_wr
);
    logic [1:0] cnt = 2'h0;
    logic       drv = 1'b0;
    logic       wait_q = 1'b0;
    logic [7:0] last = 8'h00;
    wire  logic strobed = !(dstb_low && astb_low);

    // Wait stays asserted between cycles and is released once the byte is taken.
    assign wait_low = wait_q;

    // Released lines show the inverse of their last level, never a stale byte.
    assign din = !oe_low ? dout : (drv ? rd_byte : ~last);

    always @(posedge clk) begin
        last <= din;
        if (strobed) begin
            drv <= wr_low;
            cnt <= cnt + 2'h1;
            if (cnt == lat && !stall && !wait_q) begin
                wait_q   <= 1'b1;
                got      <= dout;
                got_adr  <= !astb_low;
                got_wr   <= !wr_low;
            end
        end else begin
            cnt      <= 2'h0;
            drv      <= 1'b0;
            wait_q   <= 1'b0;
        end
    end
endmodule // eppp_periph

`default_nettype wire

// [tb/test_eppp_port.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, (e), (g)); end end

module test_eppp_port
    import eppp_pkg::*;
;
    logic       clk, resetn, io_wr, io_rd, io_ready, busy, online, paper, fault_low;
    logic       ack_low, stb_low, feed_low, init_low, sel_low, irq, wr_low, dstb_low;
    logic       astb_low, wait_low, oe_low, stall, got_adr, got_wr;
    logic [1:0] mode, lat;
    logic [2:0] io_addr;
    logic [7:0] io_wdata, io_rdata, pdout, pdin, got, rd_byte, q;
    int         cnt;
    int         num_errors = 0;
    int         n_compared = 0;

    eppp_port #(.WDOG_LIMIT(20)) DUT (
        .CLK(clk), .RESETN(resetn), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
        .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_READY(io_ready), .PORT_MODE(mode),
        .FAULT_INPUT_LOW(fault_low), .PRINTER_ONLINE(online), .PAPER_OUT(paper),
        .CHAR_ACCEPTED_LOW(ack_low), .BUSY(busy), .DATA_STROBE_PIN_LOW(stb_low),
        .LINE_FEED_PIN_LOW(feed_low), .PRINTER_INIT_LOW(init_low),
        .SELECT_PRINTER_PIN_LOW(sel_low), .IRQ(irq), .WRITE_DIRECTION_LOW(wr_low),
        .DATA_PHASE_STROBE_LOW(dstb_low), .ADDRESS_PHASE_STROBE_LOW(astb_low),
        .WAIT_HANDSHAKE_LOW(wait_low), .PORT_DATA_IN(pdin), .PORT_DATA_OUT(pdout),
        .PORT_DATA_OE_LOW(oe_low)
    );

    eppp_periph u_per (
        .clk(clk), .stall(stall), .lat(lat), .rd_byte(rd_byte), .dstb_low(dstb_low),
        .astb_low(astb_low), .wr_low(wr_low), .oe_low(oe_low), .dout(pdout),
        .wait_low(wait_low), .din(pdin), .got(got), .got_adr(got_adr), .got_wr(got_wr)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // One host access; entered and left just after a rising edge.
    task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        do begin
            @(posedge clk);
            k++;
        end while (io_ready !== 1'b1 && k < 400);
        q = io_rdata;
        `CHK("io ready", 1'b1, io_ready)
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic endt(input string s);
        $display("end of %s", s);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        {io_wr, io_rd, io_addr, io_wdata, stall, lat, rd_byte} = '0;
        {busy, ack_low, paper, online, fault_low} = 5'h1F;
        mode = MODE_SPP;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        `CHK("reset pins", 4'hB, {sel_low, init_low, feed_low, stb_low})
        acc(OFS_CONTROL, 1'b0, 8'h00);
        `CHK("ctl reset", 8'h00, q)
        acc(OFS_CONTROL, 1'b1, 8'hFF);
        acc(OFS_CONTROL, 1'b0, 8'h00);
        `CHK("ctl fixed bits", 8'h3F, q)
        `CHK("ctl pins", 4'h4, {sel_low, init_low, feed_low, stb_low})
        endt("control");
        for (int i = 0; i < 2; i++) begin
            {busy, ack_low, paper, online, fault_low} = i ? 5'h0A : 5'h15;
            repeat (3) @(posedge clk);
            #1;
            acc(OFS_STATUS, 1'b0, 8'h00);
            `CHK("status", i ? 8'hD0 : 8'h28, q)
        end
        for (int en = 1; en >= 0; en--) begin
            acc(OFS_CONTROL, 1'b1, {3'h0, en[0], 4'h0});
            ack_low = 1'b0;
            repeat (6) @(posedge clk);
            #1;
            ack_low = 1'b1;
            cnt = 0;
            repeat (6) begin
                @(posedge clk);
                if (irq === 1'b1) cnt++;
            end
            #1;
            `CHK("irq pulses", en, cnt)
        end
        endt("status and irq");
        acc(OFS_DATA, 1'b1, 8'h3C);
        `CHK("data lines", 8'h3C, pdout)
        acc(OFS_DATA, 1'b0, 8'h00);
        `CHK("live read", 8'h3C, q)
        acc(OFS_CONTROL, 1'b1, 8'h20);
        `CHK("printer drive", 1'b0, oe_low)
        mode = MODE_BIDI;
        repeat (2) @(posedge clk);
        #1;
        `CHK("bidi input", 1'b1, oe_low)
        acc(3'h5, 1'b0, 8'h00);
        `CHK("port off", 8'h00, q)
        endt("standard modes");
        mode = MODE_EPP;
        acc(OFS_CONTROL, 1'b1, 8'h04);
        for (int a = 3; a < 8; a++) begin
            lat = a[1:0];
            acc(3'(a), 1'b1, 8'(8'h50 + a));
            `CHK("epp write", 8'(8'h50 + a), got)
            `CHK("epp write kind", {a == 3, 1'b1}, {got_adr, got_wr})
        end
        for (int a = 3; a < 5; a++) begin
            rd_byte = 8'hC3 ^ 8'(a);
            acc(3'(a), 1'b0, 8'h00);
            `CHK("epp read", rd_byte, q)
            `CHK("epp read kind", {a == 3, 1'b0}, {got_adr, got_wr})
        end
        endt("epp");
        acc(OFS_CONTROL, 1'b1, 8'h24);
        acc(3'h4, 1'b1, 8'hA5);
        `CHK("dir write", 1'b0, got_wr)
        acc(OFS_STATUS, 1'b0, 8'h00);
        `CHK("dir no error", 1'b0, q[0])
        acc(OFS_CONTROL, 1'b1, 8'h21);
        acc(3'h4, 1'b0, 8'h00);
        `CHK("strobe override", 1'b1, got_wr)
        endt("direction");
        acc(OFS_CONTROL, 1'b1, 8'h04);
        stall = 1'b1;
        acc(3'h7, 1'b1, 8'h77);
        stall = 1'b0;
        acc(OFS_STATUS, 1'b0, 8'h00);
        `CHK("timeout set", 1'b1, q[0])
        acc(OFS_STATUS, 1'b1, 8'h00);
        acc(OFS_STATUS, 1'b0, 8'h00);
        `CHK("zero write", 1'b1, q[0])
        acc(OFS_STATUS, 1'b1, 8'h01);
        acc(OFS_STATUS, 1'b0, 8'h00);
        `CHK("one write", 1'b0, q[0])
        stall = 1'b1;
        acc(3'h4, 1'b1, 8'h11);
        stall = 1'b0;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        acc(OFS_STATUS, 1'b0, 8'h00);
        `CHK("reset clears", 1'b0, q[0])
        `CHK("reset pins again", 4'hB, {sel_low, init_low, feed_low, stb_low})
        endt("timeout");
        tally_and_finish();
    end

    initial begin
        #(40 * 20000);
        num_errors++;
        tally_and_finish();
    end
endmodule // test_eppp_port

`default_nettype wire
